// ===== tb/rdec_bus_peer.sv
// far station on the differential pair, seen through its comparator view
// assumes the bench raises talk_in on a two-wire pair only while the local driver is off
`default_nettype none

module rdec_bus_peer (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  input  wire logic talk_in,
  output var  logic rx_inv_out,
  output var  logic rx_non_out,
  output var  logic carrier_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] lfsr;
  logic       flt;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lfsr <= 8'h5a;
      flt  <= 1'b0;
    end else begin
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      flt  <= ~flt;
    end
  end

  // a released pair floats: it toggles so no one can lean on a held level
  always_comb begin
    if (talk_in) begin
      rx_inv_out  = ~lfsr[0];
      rx_non_out  = lfsr[0];
      carrier_out = 1'b1;
    end else begin
      rx_inv_out  = flt;
      rx_non_out  = lfsr[1];
      carrier_out = 1'b0;
    end
  end
endmodule

`default_nettype wire

// ===== tb/rdec_top_tb_top.sv
// self-checking bench for the line driver enable control
// assumes TICK_CYCLES is shrunk to 4 so every delay scales by 4/2500
`default_nettype none
`include "rdec_params.svh"

module rdec_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rdec_pkg::*;

  localparam int unsigned TB_TICK = 4;
  localparam int          LIMIT   = 90000;

  logic         clk_in, rst_b_in, rts_in, cd_in, tx_data_in, talk;
  logic         rx_inv, rx_non, carrier;
  logic         drv, rcv, rxd, cts, cd, dsr, tx_led, rx_led, cd_led;
  rdec_cfg_t    cfg;
  rdec_txpair_t tx_pair;
  int           error_cnt, n_compared, seed, cyc, n, i;
  int           dly_us  [3] = '{`RDEC_DLY_A_US, `RDEC_DLY_B_US, `RDEC_DLY_C_US};
  int           hold_us [5] = '{`RDEC_HOLD_A_US, `RDEC_HOLD_B_US, `RDEC_HOLD_C_US,
                                `RDEC_HOLD_D_US, `RDEC_HOLD_E_US};
  int           turn_us [5] = '{`RDEC_TURN_A_US, `RDEC_TURN_B_US, `RDEC_TURN_C_US,
                                `RDEC_TURN_D_US, `RDEC_TURN_E_US};

  rdec_top #(.TICK_CYCLES(TB_TICK)) dut_u (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .cfg_in(cfg), .rts_in(rts_in), .cd_in(cd_in),
    .tx_data_in(tx_data_in), .line_carrier_in(carrier), .rx_line_inverting_in(rx_inv),
    .rx_line_noninverting_in(rx_non), .tx_pair_out(tx_pair), .driver_enable_out(drv),
    .receiver_enable_out(rcv), .rx_data_out(rxd), .cts_out(cts), .cd_out(cd),
    .dsr_out(dsr), .tx_led_out(tx_led), .rx_led_out(rx_led), .cd_led_out(cd_led));

  rdec_bus_peer peer_u (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .talk_in(talk),
    .rx_inv_out(rx_inv), .rx_non_out(rx_non), .carrier_out(carrier));

  // ----------------------------------------------------------------------
  // clock, watchdog, checks
  // ----------------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    cyc++;
    if (cyc == LIMIT) begin
      error_cnt++;
      $display("ERROR run length expected below %0d seen %0d", LIMIT, cyc);
      close_out();
    end
  end

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_rng(input string what, input int lo, input int hi, input int got);
    n_compared++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  // settings are static, so each new setting goes in under reset
  task automatic setup(input rdec_cfg_t c);
    @(negedge clk_in);
    rst_b_in   = 1'b0;
    cfg        = c;
    rts_in     = 1'b0;
    cd_in      = 1'b0;
    tx_data_in = 1'b1;
    talk       = 1'b0;
    repeat (2) @(negedge clk_in);
    rst_b_in = 1'b1;
    repeat (2) @(negedge clk_in);
  endtask

  function automatic logic pick(input int w);
    return (w == 0) ? drv : ((w == 1) ? rcv : cts);
  endfunction

  task automatic wait_lvl(input int w, input logic v, input int lim, output int cnt);
    cnt = 0;
    while (pick(w) !== v && cnt < lim) begin
      @(negedge clk_in);
      cnt++;
    end
  endtask

  function automatic int cyc_of(input int us);
    return us / `RDEC_TICK_US * TB_TICK;
  endfunction

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  initial begin
    rdec_cfg_t c;
    int        lo;
    logic      d;
    logic      exp_rx;
    seed = 70;
    error_cnt = 0;
    n_compared = 0;
    cyc = 0;
    rst_b_in = 1'b0;
    cfg = '0;
    rts_in = 1'b0;
    cd_in = 1'b0;
    tx_data_in = 1'b1;
    talk = 1'b0;
    repeat (12) @(negedge clk_in);
    rst_b_in = 1'b1;
    for (i = 0; i < 3; i++) begin
      c = '0;
      c.enable_delay_select = 2'(i);
      setup(c);
      rts_in = 1'b1;
      wait_lvl(0, 1'b1, 20000, n);
      lo = cyc_of(dly_us[i]);
      chk_rng("enable delay", lo, lo + TB_TICK + 6, n);
      chk("cts with driver", 1'b1, cts);
      rts_in = 1'b0;
      repeat (3) @(negedge clk_in);
      chk("driver after rts drop", 1'b0, drv);
    end
    c = '0;
    c.enable_delay_select = 2'h2;
    c.cts_inhibit_select = 1'b1;
    setup(c);
    talk = 1'b1;
    repeat (3) @(negedge clk_in);
    rts_in = 1'b1;
    repeat (10) @(negedge clk_in);
    chk("cts inhibited", 1'b0, cts);
    talk = 1'b0;
    rts_in = 1'b0;
    repeat (3) @(negedge clk_in);
    rts_in = 1'b1;
    repeat (8) @(negedge clk_in);
    chk("cts without carrier", 1'b1, cts);
    // data sourced enable: the control lead alone must not drive
    for (i = 0; i < 5; i++) begin
      c = '0;
      c.enable_source_select = 1'b1;
      c.data_hold_time_select = 3'(i);
      setup(c);
      rts_in = 1'b1;
      repeat (40) @(negedge clk_in);
      chk("driver ignores rts", 1'b0, drv);
      tx_data_in = 1'b0;
      repeat (3) @(negedge clk_in);
      chk("driver on data", 1'b1, drv);
      repeat (6) @(negedge clk_in);  // bit time kept above the rate limit
      tx_data_in = 1'b1;
      wait_lvl(0, 1'b0, 30000, n);
      lo = cyc_of(hold_us[i]);
      chk_rng("data hold", lo, lo + TB_TICK + 6, n);
    end
    tx_data_in = 1'b0;
    repeat (8) @(negedge clk_in);
    tx_data_in = 1'b1;
    repeat (40) @(negedge clk_in);
    tx_data_in = 1'b0;
    repeat (8) @(negedge clk_in);
    tx_data_in = 1'b1;
    wait_lvl(0, 1'b0, 1000, n);
    chk_rng("hold restart", cyc_of(hold_us[4]), cyc_of(hold_us[4]) + TB_TICK + 6, n);
    for (i = 0; i < 5; i++) begin
      c = '0;
      c.enable_source_select = 1'b1;
      c.data_hold_time_select = 3'h4;
      c.wire_count_select = 1'b1;
      c.turnaround_time_select = 3'(i);
      setup(c);
      tx_data_in = 1'b0;
      repeat (8) @(negedge clk_in);
      chk("receiver off while driving", 1'b0, rcv);
      chk("rx data while off", 1'b1, rxd);
      tx_data_in = 1'b1;
      wait_lvl(1, 1'b1, 16000, n);
      lo = cyc_of(hold_us[4] + turn_us[i]);
      chk_rng("hold plus turnaround", lo, lo + 2 * TB_TICK + 10, n);
    end
    c = '0;
    c.enable_delay_select = 2'h3;
    c.line_bias_switch = 1'b1;
    setup(c);
    talk = 1'b1;
    repeat (200) begin
      d = 1'($random(seed));
      tx_data_in = d;
      rts_in = 1'($random(seed));
      exp_rx = rx_inv & ~rx_non;
      @(negedge clk_in);
      chk("driver permanent", 1'b1, drv);
      chk("tx led", ~d, tx_led);
      chk("tx line inverting", ~d, tx_pair.tx_line_inverting);
      chk("tx line noninverting", d, tx_pair.tx_line_noninverting);
      chk("rx data", ~exp_rx, rxd);
      chk("dsr in dce role", 1'b1, dsr);
      chk("rx led", exp_rx, rx_led);
      chk("carrier forced", 1'b1, cd);
      chk("carrier led forced", 1'b1, cd_led);
    end
    c.line_bias_switch = 1'b0;
    c.loopback_switch = 1'b1;
    setup(c);
    repeat (3) @(negedge clk_in);
    chk("carrier follows line", 1'b0, cd);
    tx_data_in = 1'b0;
    repeat (2) @(negedge clk_in);
    chk("loopback data", 1'b0, rxd);
    c = '0;
    c.port_role_select = 1'b1;
    c.enable_delay_select = 2'h2;
    setup(c);
    cd_in = 1'b1;
    wait_lvl(0, 1'b1, 20, n);
    chk_rng("carrier lead enable", 0, 4, n);
    chk("cts unused in terminal role", 1'b0, cts);
    chk("dsr in dte role", 1'b0, dsr);
    c.enable_delay_select = 2'h3;
    setup(c);
    repeat (3) @(negedge clk_in);
    chk("carrier lead ignored", 1'b1, drv);
    close_out();
  end
endmodule

`default_nettype wire

// ===== verilog/rdec_delay_timer.sv
// down counter in timebase ticks; busy while the delay runs
// assumes tick_in is a one-cycle pulse from rdec_timebase
`default_nettype none
`include "rdec_params.svh"

module rdec_delay_timer (
  input  wire logic                   clk_in,
  input  wire logic                   rst_b_in,
  input  wire logic                   start_in,
  input  wire logic [`RDEC_TMR_W-1:0] load_in,
  input  wire logic                   tick_in,
  output logic                        busy_out
);
  import rdec_pkg::*;

  logic [`RDEC_TMR_W-1:0] cnt;

  // one extra tick since the first tick may land right after the start,
  // so the delay is never shorter than asked
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt <= '0;
    end else if (start_in) begin
      cnt <= (load_in == '0) ? '0 : `RDEC_TMR_W'(load_in + 1'b1);
    end else if (tick_in && cnt != '0) begin
      cnt <= `RDEC_TMR_W'(cnt - 1'b1);
    end
  end

  assign busy_out = (cnt != '0);
endmodule

`default_nettype wire

// ===== verilog/rdec_params.svh
// timing and select constants for the line driver enable control
// assumes a 250 MHz system clock; all delays count 10 us timebase ticks
`ifndef RDEC_PARAMS_SVH
`define RDEC_PARAMS_SVH

// ----------------------------------------------------------------------
// clock and timebase
// ----------------------------------------------------------------------
`define RDEC_CLK_PERIOD_PS 4000
`define RDEC_TICK_US       10
`define RDEC_TICK_CYCLES   ((`RDEC_TICK_US * 1000000) / `RDEC_CLK_PERIOD_PS)

// ----------------------------------------------------------------------
// enable delay settings, times in us
// ----------------------------------------------------------------------
`define RDEC_DLY_A_US      30000
`define RDEC_DLY_B_US      10000
`define RDEC_DLY_C_US      0
`define RDEC_DLY_SEL_A     2'h0
`define RDEC_DLY_SEL_B     2'h1
`define RDEC_DLY_SEL_C     2'h2
`define RDEC_DLY_SEL_ON    2'h3

// ----------------------------------------------------------------------
// data hold and turnaround settings, times in us
// ----------------------------------------------------------------------
`define RDEC_HOLD_A_US     70000
`define RDEC_HOLD_B_US     7000
`define RDEC_HOLD_C_US     2000
`define RDEC_HOLD_D_US     700
`define RDEC_HOLD_E_US     150
`define RDEC_TURN_A_US     0
`define RDEC_TURN_B_US     100
`define RDEC_TURN_C_US     1000
`define RDEC_TURN_D_US     5000
`define RDEC_TURN_E_US     35000
`define RDEC_SEL_A         3'h0
`define RDEC_SEL_B         3'h1
`define RDEC_SEL_C         3'h2
`define RDEC_SEL_D         3'h3
`define RDEC_SEL_E         3'h4

`define RDEC_TMR_W         13
`define RDEC_TICK_W        16

`endif

// ===== verilog/rdec_pkg.sv
// types shared by the line driver enable control
// assumes rdec_params.svh supplies the numeric constants
`default_nettype none

package rdec_pkg;

  typedef enum logic [3:0] {
    RDEC_IDLE  = 4'b0001,
    RDEC_WAIT  = 4'b0010,
    RDEC_DRIVE = 4'b0100,
    RDEC_HOLD  = 4'b1000
  } rdec_state_t;

  // jumper and switch settings, static during operation
  typedef struct packed {
    logic [1:0] enable_delay_select;
    logic       enable_source_select;    // 0 control lead, 1 data
    logic [2:0] data_hold_time_select;
    logic [2:0] turnaround_time_select;
    logic       wire_count_select;       // 0 four wire, 1 two wire
    logic       cts_inhibit_select;
    logic       port_role_select;        // 0 dce, 1 dte
    logic       loopback_switch;
    logic       line_bias_switch;
  } rdec_cfg_t;

  typedef struct packed {
    logic tx_line_inverting;
    logic tx_line_noninverting;
  } rdec_txpair_t;

endpackage

`default_nettype wire

// ===== verilog/rdec_timebase.sv
// free running timebase: one-cycle tick every TICK_CYCLES clocks
// assumes a single clock domain with asynchronous active-low reset
`default_nettype none
`include "rdec_params.svh"

module rdec_timebase #(
  parameter int unsigned TICK_CYCLES = `RDEC_TICK_CYCLES
) (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  output var  logic tick_out
);
  import rdec_pkg::*;

  logic [`RDEC_TICK_W-1:0] div;

  // fixed timebase for every delay counter
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div      <= '0;
      tick_out <= 1'b0;
    end else if (div == `RDEC_TICK_W'(TICK_CYCLES - 1)) begin
      div      <= '0;
      tick_out <= 1'b1;
    end else begin
      div      <= `RDEC_TICK_W'(div + 1'b1);
      tick_out <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// ===== verilog/rdec_top.sv
// line driver enable control of a serial-to-differential converter
// assumes all pin inputs are synchronous to clk_in; settings are static
`default_nettype none
`include "rdec_params.svh"

module rdec_top #(
  parameter int unsigned TICK_CYCLES = `RDEC_TICK_CYCLES
) (
  input  wire logic               clk_in,
  input  wire logic               rst_b_in,
  input  wire rdec_pkg::rdec_cfg_t cfg_in,
  input  wire logic               rts_in,
  input  wire logic               cd_in,
  input  wire logic               tx_data_in,
  input  wire logic               line_carrier_in,
  input  wire logic               rx_line_inverting_in,
  input  wire logic               rx_line_noninverting_in,
  output rdec_pkg::rdec_txpair_t  tx_pair_out,
  output logic                    driver_enable_out,
  output logic                    receiver_enable_out,
  output logic                    rx_data_out,
  output logic                    cts_out,
  output logic                    cd_out,
  output logic                    dsr_out,
  output logic                    tx_led_out,
  output logic                    rx_led_out,
  output logic                    cd_led_out
);
  import rdec_pkg::*;

  // ----------------------------------------------------------------------
  // delay lookup
  // ----------------------------------------------------------------------
  function automatic logic [`RDEC_TMR_W-1:0] to_ticks(input int unsigned us);
    to_ticks = `RDEC_TMR_W'(us / `RDEC_TICK_US);
  endfunction

  function automatic logic [`RDEC_TMR_W-1:0] dly_ticks(input logic [1:0] sel);
    case (sel)
      `RDEC_DLY_SEL_A: dly_ticks = to_ticks(`RDEC_DLY_A_US);
      `RDEC_DLY_SEL_B: dly_ticks = to_ticks(`RDEC_DLY_B_US);
      default:         dly_ticks = to_ticks(`RDEC_DLY_C_US);
    endcase
  endfunction

  function automatic logic [`RDEC_TMR_W-1:0] hold_ticks(input logic [2:0] sel);
    case (sel)
      `RDEC_SEL_A: hold_ticks = to_ticks(`RDEC_HOLD_A_US);
      `RDEC_SEL_C: hold_ticks = to_ticks(`RDEC_HOLD_C_US);
      `RDEC_SEL_D: hold_ticks = to_ticks(`RDEC_HOLD_D_US);
      `RDEC_SEL_E: hold_ticks = to_ticks(`RDEC_HOLD_E_US);
      default:     hold_ticks = to_ticks(`RDEC_HOLD_B_US);
    endcase
  endfunction

  function automatic logic [`RDEC_TMR_W-1:0] turn_ticks(input logic [2:0] sel);
    case (sel)
      `RDEC_SEL_A: turn_ticks = to_ticks(`RDEC_TURN_A_US);
      `RDEC_SEL_C: turn_ticks = to_ticks(`RDEC_TURN_C_US);
      `RDEC_SEL_D: turn_ticks = to_ticks(`RDEC_TURN_D_US);
      `RDEC_SEL_E: turn_ticks = to_ticks(`RDEC_TURN_E_US);
      default:     turn_ticks = to_ticks(`RDEC_TURN_B_US);
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // timebase and timers
  // ----------------------------------------------------------------------
  logic        tick;
  logic        dly_start;
  logic        dly_busy;
  logic        hold_start;
  logic        hold_busy;
  logic        turn_start;
  logic        turn_busy;
  rdec_state_t state;
  rdec_state_t next_state;
  logic        txd_prev;
  logic        rts_prev;
  logic        inhibit;
  logic        drv_prev;

  rdec_timebase #(.TICK_CYCLES(TICK_CYCLES)) u_tb (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .tick_out (tick)
  );

  rdec_delay_timer u_dly (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .start_in (dly_start),
    .load_in  (dly_ticks(cfg_in.enable_delay_select)),
    .tick_in  (tick),
    .busy_out (dly_busy)
  );

  rdec_delay_timer u_hold (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .start_in (hold_start),
    .load_in  (hold_ticks(cfg_in.data_hold_time_select)),
    .tick_in  (tick),
    .busy_out (hold_busy)
  );

  rdec_delay_timer u_turn (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .start_in (turn_start),
    .load_in  (turn_ticks(cfg_in.turnaround_time_select)),
    .tick_in  (tick),
    .busy_out (turn_busy)
  );

  // ----------------------------------------------------------------------
  // enable source and driver state
  // ----------------------------------------------------------------------
  logic perm_on;
  logic data_mode;
  logic lead;
  logic txd_rise;
  logic drv_en;
  logic cd_now;

  assign perm_on   = (cfg_in.enable_delay_select == `RDEC_DLY_SEL_ON);
  assign data_mode = cfg_in.enable_source_select;
  // a terminal has no clear-to-send, so carrier detect is the lead
  assign lead      = cfg_in.port_role_select ? cd_in : rts_in;
  assign txd_rise  = tx_data_in && !txd_prev;
  assign cd_now    = cfg_in.line_bias_switch || line_carrier_in;

  always_comb begin
    next_state = state;
    dly_start  = 1'b0;
    hold_start = 1'b0;
    if (perm_on) begin
      next_state = RDEC_IDLE;
    end else if (!data_mode) begin
      case (state)
        RDEC_IDLE: begin
          if (lead) begin
            next_state = RDEC_WAIT;
            dly_start  = 1'b1;
          end
        end
        RDEC_WAIT: begin
          if (!lead) begin
            next_state = RDEC_IDLE;
          end else if (!dly_busy) begin
            next_state = RDEC_DRIVE;
          end
        end
        default: begin
          if (!lead) begin
            next_state = RDEC_IDLE;
          end else begin
            next_state = RDEC_DRIVE;
          end
        end
      endcase
    end else begin
      case (state)
        RDEC_DRIVE, RDEC_HOLD: begin
          if (!tx_data_in) begin
            next_state = RDEC_DRIVE;
          end else if (txd_rise) begin
            next_state = RDEC_HOLD;
            hold_start = 1'b1;
          end else if (state == RDEC_HOLD && !hold_busy) begin
            next_state = RDEC_IDLE;
          end else if (state == RDEC_DRIVE) begin
            next_state = RDEC_HOLD;
            hold_start = 1'b1;
          end
        end
        default: begin
          if (!tx_data_in) begin
            next_state = RDEC_DRIVE;
          end else begin
            next_state = RDEC_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= RDEC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      txd_prev <= 1'b1;
      rts_prev <= 1'b0;
      drv_prev <= 1'b0;
    end else begin
      txd_prev <= tx_data_in;
      rts_prev <= rts_in;
      drv_prev <= drv_en;
    end
  end

  assign drv_en = perm_on || state == RDEC_DRIVE || state == RDEC_HOLD;

  // ----------------------------------------------------------------------
  // clear-to-send inhibit
  // ----------------------------------------------------------------------
  logic inh_now;

  // carrier seen at the rts rising edge blocks cts until rts drops
  assign inh_now = cfg_in.cts_inhibit_select && rts_in && !rts_prev && cd_now;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      inhibit <= 1'b0;
    end else if (!rts_in) begin
      inhibit <= 1'b0;
    end else if (inh_now) begin
      inhibit <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // half-duplex turnaround
  // ----------------------------------------------------------------------
  // starts only once the driver drops, which in data mode is after the
  // hold time, so the two delays add
  assign turn_start = cfg_in.wire_count_select && drv_prev && !drv_en;

  // ----------------------------------------------------------------------
  // registered pin outputs
  // ----------------------------------------------------------------------
  logic rx_zero;
  logic rx_en;

  assign rx_zero = rx_line_inverting_in && !rx_line_noninverting_in;
  assign rx_en   = !cfg_in.wire_count_select
                   || (!drv_en && !turn_busy && !turn_start);

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_pair_out         <= '0;
      driver_enable_out   <= 1'b0;
      receiver_enable_out <= 1'b0;
      rx_data_out         <= 1'b1;
      cts_out             <= 1'b0;
      cd_out              <= 1'b0;
      dsr_out             <= 1'b0;
      tx_led_out          <= 1'b0;
      rx_led_out          <= 1'b0;
      cd_led_out          <= 1'b0;
    end else begin
      // a zero drives the inverting line positive
      tx_pair_out.tx_line_inverting    <= drv_en && !tx_data_in;
      tx_pair_out.tx_line_noninverting <= drv_en && tx_data_in;
      driver_enable_out   <= drv_en;
      receiver_enable_out <= rx_en;
      // loopback returns terminal data; a disabled receiver reads as mark
      rx_data_out <= cfg_in.loopback_switch ? tx_data_in : !(rx_en && rx_zero);
      cts_out     <= !cfg_in.port_role_select && rts_in && drv_en
                     && !inhibit && !inh_now;
      cd_out      <= cd_now;
      dsr_out     <= !cfg_in.port_role_select;
      tx_led_out  <= drv_en && !tx_data_in;
      rx_led_out  <= rx_zero;
      cd_led_out  <= cd_now;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  localparam int unsigned DLY_A_CYC = (`RDEC_DLY_A_US / `RDEC_TICK_US) * TICK_CYCLES;

  logic [23:0] lead_cnt;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lead_cnt <= '0;
    end else if (!lead) begin
      lead_cnt <= '0;
    end else if (lead_cnt != 24'hffffff) begin
      lead_cnt <= 24'(lead_cnt + 1'b1);
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  a_perm_drive_on: assert property (perm_on |=> driver_enable_out)
    else $error("driver not enabled in permanent-on setting");
  a_delay_min_wait: assert property ($rose(driver_enable_out) && !data_mode
      && cfg_in.enable_delay_select == `RDEC_DLY_SEL_A |-> lead_cnt >= 24'(DLY_A_CYC))
    else $error("driver enabled before the long enable delay");
  a_cts_with_drive: assert property (cts_out |-> driver_enable_out && $past(rts_in))
    else $error("clear-to-send without driver enabled");
  a_lead_drop_off: assert property (!data_mode && !perm_on && !lead ##1
      !data_mode && !perm_on |=> !driver_enable_out)
    else $error("driver stayed on after control lead dropped");
  a_data_keeps_on: assert property (data_mode && !perm_on && !tx_data_in ##1
      data_mode && !perm_on |=> driver_enable_out)
    else $error("driver off while data is low");
  a_rx_turnaround: assert property (cfg_in.wire_count_select && $fell(driver_enable_out)
      && cfg_in.turnaround_time_select != `RDEC_SEL_A |-> !receiver_enable_out [*2])
    else $error("receiver enabled without turnaround");
  a_rx_off_drive: assert property (cfg_in.wire_count_select && driver_enable_out
      |-> !receiver_enable_out)
    else $error("receiver enabled while driving two wire");
  a_inhibit_cts: assert property (inh_now |=> !cts_out ##1 (!cts_out || !rts_in))
    else $error("clear-to-send raised despite carrier inhibit");
  a_tx_led_zero: assert property (tx_led_out == (tx_pair_out.tx_line_inverting
      && !tx_pair_out.tx_line_noninverting))
    else $error("transmit indicator disagrees with line");
  a_rx_led_zero: assert property (##1 rx_led_out == $past(rx_zero))
    else $error("receive indicator disagrees with line");
  a_bias_cd_on: assert property (cfg_in.line_bias_switch |=> cd_out && cd_led_out)
    else $error("carrier detect off with line bias on");

  c_ctrl_drive: cover property (!data_mode ##1 $rose(driver_enable_out));
  c_hold_release: cover property (data_mode ##1 $fell(driver_enable_out));
  c_turn_done: cover property (cfg_in.wire_count_select ##1 $rose(receiver_enable_out));
  c_inhibit: cover property (inh_now ##1 inhibit);
endmodule

`default_nettype wire
